/* hw/pfds_defs.vh */
// Purpose: constants of the pin function and drive select block
// Assumes: Avalon-MM slave with 32-bit words, byte addresses
// Notes:   offsets are byte addresses of aligned words
`ifndef PFDS_DEFS_VH
`define PFDS_DEFS_VH
// register byte offsets
`define PFDS_OFF_DRV_LOW    4'h0
`define PFDS_OFF_DRV_HIGH   4'h4
`define PFDS_OFF_PA_LOW     4'h8
`define PFDS_OFF_PA_HIGH    4'hc
`define PFDS_OFF_PB_LOW     5'h10
`define PFDS_OFF_PORT_DIR   5'h14
`define PFDS_OFF_PORT_DATA  5'h18
`define PFDS_OFF_PIN_LEVEL  5'h1c
// reset values
`define PFDS_RST_SEL        8'h00
`define PFDS_RST_DIR        12'hfff
`define PFDS_RST_DATA       12'hfff
// implemented bits of the second drive register
`define PFDS_DRV_HIGH_MASK  8'h3f
// select codes
`define PFDS_SEL_GPIO       2'h0
`define PFDS_SEL_ALT1       2'h1
`define PFDS_SEL_ALT2       2'h2
`define PFDS_SEL_ALT3       2'h3
`endif

/* hw/pfds_pin_cell.v */
// Purpose: one pin driver with function and drive selection
// Assumes: inputs on the same clock as the pin output registers
// Notes:   output flopped in the parent, this cell is combinational
`timescale 1ns/1ns
`default_nettype none
module pfds_pin_cell (
  input  wire       dir_in_in,
  input  wire       latch_in,
  input  wire       per_oe_in,
  input  wire       per_data_in,
  input  wire       analog_in,
  input  wire [1:0] drive_in,
  output wire       pin_out,
  output wire       pin_oe_out,
  output wire [1:0] drive_out
);
  // peripheral owns the pin when it selects an output, else the port latch
  wire cmos_out;
  assign cmos_out   = ~per_oe_in & ~analog_in & ~dir_in_in;
  // RQ21 peripheral drives pin
  assign pin_out    = per_oe_in ? per_data_in : latch_in;
  assign pin_oe_out = ~analog_in & (per_oe_in | ~dir_in_in);
  // RQ1 drive only when push-pull
  assign drive_out  = (cmos_out | per_oe_in) ? drive_in : 2'h0;
endmodule
`default_nettype wire

/* hw/pfds_top.v */
// Purpose: pin function and drive strength selection for ports A and B
// Assumes: Avalon-MM master, 100 MHz clk_in, pins synchronised here
// Notes:   every read or write answers one cycle after it is presented
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pfds_defs.vh"
// Function
// RQ1: drive level applies only to push-pull outputs
// RQ2: two bits give drive levels zero to three
// RQ3: low drive register covers ports A, B
// RQ4: high drive register covers C, D; 7~6 zero
// RQ5: PA3 gpio/external_irq_line_0/cap, spi out, tx0, an3
// RQ6: PA2 gpio, spi/i2c data, uart rx/tx, timer2
// RQ7: PA1 gpio/external_irq_line_1, spi select, opamp1 out/in
// RQ8: PA0 gpio twice, spi/i2c clock, timer1 inverted
// RQ9: PA7 gpio/captures, spi clock, an1, vref
// RQ10: PA6 gpio, ptimer0 out, spi data, uart
// RQ11: PA5 gpio/clock twice, stimer1 inverted, opamp1
// RQ12: PA4 gpio/clock, stimer0 inverted, an0, opamp0
// RQ13: PB3 gpio, powerline rx, spi data, uart
// RQ14: PB2 gpio, powerline signal, spi clock, dac
// RQ15: PB1 gpio, powerline tx, spi out, tx0
// RQ16: PB0 gpio/external_irq_line_0, stimer0 out, opamp0 in, dac
// RQ17: shared digital inputs need direction input
// RQ18: software selects, configures, then enables peripheral
// RQ19: software disables peripheral before reselecting pin
// RQ20: direction one input, zero output reads latch
// RQ21: selected peripheral owns pin data path
module pfds_top (
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire [11:0] pin_level_in,
  output reg  [11:0] pin_data_out,
  output reg  [11:0] pin_oe_out,
  output reg  [11:0] pin_analog_out,
  output reg  [23:0] pin_drive_out,
  input  wire        spi_serial_out,
  input  wire        spi_sck_in,
  input  wire        spi_sck_oe_in,
  input  wire        spi_data_o_in,
  input  wire        spi_data_oe_in,
  input  wire        spi_chip_select_line,
  input  wire        spi_cs_oe_in,
  input  wire        uart0_transmit,
  input  wire        uart0_rxtx_oe_in,
  input  wire        per_timer2_inverted_out,
  input  wire        per_timer1_inverted_out,
  input  wire        per_timer0_out,
  input  wire        std_timer1_inverted_out,
  input  wire        std_timer0_inverted_out,
  input  wire        std_timer0_out,
  input  wire        powerline_transmit_out,
  output reg         external_irq_line_0_out,
  output reg         external_irq_line_1_out,
  output reg         std_timer1_capture_in_out,
  output reg         std_timer0_capture_in_out,
  output reg         per_timer0_capture_in_out,
  output reg         std_timer0_clock_in_out,
  output reg         per_timer0_clock_in_out,
  output reg         spi_in_or_i2c_data_out,
  output reg         spi_sck_out,
  output reg         spi_chip_select_in_out,
  output reg         uart0_receive_transmit_out,
  output reg         powerline_receive_in_out,
  output reg         powerline_signal_input_out
);
  //----------------------------------------
  // reset release
  //----------------------------------------
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  //----------------------------------------
  // pin synchroniser, two stages before use
  //----------------------------------------
  reg [11:0] pin_s1_q;
  reg [11:0] pin_s2_q;
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
    end else begin
      pin_s1_q <= pin_level_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  //----------------------------------------
  // registers
  //----------------------------------------
  reg  [7:0]  drv_low_q;
  reg  [7:0]  drv_high_q;
  reg  [7:0]  pa_low_q;
  reg  [7:0]  pa_high_q;
  reg  [7:0]  pb_low_q;
  reg  [11:0] dir_q;     // one bit per pin, 1 is input: pa 7..0, pb 11..8
  reg  [11:0] data_q;
  reg         ack_q;
  wire [7:0]  wbyte;
  wire        wr_go;
  wire [4:0]  adr;
  assign wbyte = avs_writedata_in[7:0];
  assign adr   = {avs_address_in[4:2], 2'b00};
  // a request is taken on the cycle waitrequest is low
  assign wr_go = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];

  // waitrequest low one cycle after each request, then back high
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack_q               <= (avs_read_in | avs_write_in) & avs_waitrequest_out & ~ack_q;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out & ~ack_q);
    end
  end

  // register writes, gated by byte lane 0; dir and data take bits 11..0
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drv_low_q  <= `PFDS_RST_SEL;
      drv_high_q <= `PFDS_RST_SEL;
      pa_low_q   <= `PFDS_RST_SEL;
      pa_high_q  <= `PFDS_RST_SEL;
      pb_low_q   <= `PFDS_RST_SEL;
      dir_q      <= `PFDS_RST_DIR;
      data_q     <= `PFDS_RST_DATA;
    end else if (wr_go) begin
      case (adr)
        // RQ3 low drive fields
        {1'b0, `PFDS_OFF_DRV_LOW}:  drv_low_q  <= wbyte;
        // RQ4 unimplemented bits kept zero
        {1'b0, `PFDS_OFF_DRV_HIGH}: drv_high_q <= wbyte & `PFDS_DRV_HIGH_MASK;
        {1'b0, `PFDS_OFF_PA_LOW}:   pa_low_q   <= wbyte;
        {1'b0, `PFDS_OFF_PA_HIGH}:  pa_high_q  <= wbyte;
        `PFDS_OFF_PB_LOW:           pb_low_q   <= wbyte;
        `PFDS_OFF_PORT_DIR:         dir_q      <= avs_writedata_in[11:0];
        `PFDS_OFF_PORT_DATA:        data_q     <= avs_writedata_in[11:0];
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (adr)
      {1'b0, `PFDS_OFF_DRV_LOW}:  rd_d[7:0] = drv_low_q;
      {1'b0, `PFDS_OFF_DRV_HIGH}: rd_d[7:0] = drv_high_q;
      {1'b0, `PFDS_OFF_PA_LOW}:   rd_d[7:0] = pa_low_q;
      {1'b0, `PFDS_OFF_PA_HIGH}:  rd_d[7:0] = pa_high_q;
      `PFDS_OFF_PB_LOW:           rd_d[7:0] = pb_low_q;
      `PFDS_OFF_PORT_DIR:         rd_d[11:0] = dir_q;
      `PFDS_OFF_PORT_DATA:        rd_d[11:0] = data_q;
      // RQ20 input reads pin, output reads latch
      `PFDS_OFF_PIN_LEVEL:        rd_d[11:0] = (dir_q & pin_s2_q) | (~dir_q & data_q);
      default:                    rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in & avs_waitrequest_out & ~ack_q) begin
      avs_readdata_out <= rd_d;
    end
  end

  //----------------------------------------
  // per-pin function decode
  //----------------------------------------
  // codes per pin, pins 0..11 = pa0..pa7, pb0..pb3
  wire [1:0] s [0:11];
  assign s[0]  = pa_low_q[1:0];
  assign s[1]  = pa_low_q[3:2];
  assign s[2]  = pa_low_q[5:4];
  assign s[3]  = pa_low_q[7:6];
  assign s[4]  = pa_high_q[1:0];
  assign s[5]  = pa_high_q[3:2];
  assign s[6]  = pa_high_q[5:4];
  assign s[7]  = pa_high_q[7:6];
  assign s[8]  = pb_low_q[1:0];
  assign s[9]  = pb_low_q[3:2];
  assign s[10] = pb_low_q[5:4];
  assign s[11] = pb_low_q[7:6];

  reg [11:0] per_oe;
  reg [11:0] per_dat;
  reg [11:0] ana;
  always @* begin
    per_oe  = 12'h000;
    per_dat = 12'h000;
    ana     = 12'h000;
    // RQ8 pa0; code 11 stays gpio
    case (s[0])
      `PFDS_SEL_ALT1: begin per_oe[0] = spi_sck_oe_in; per_dat[0] = spi_sck_in; end
      `PFDS_SEL_ALT2: begin per_oe[0] = 1'b1; per_dat[0] = per_timer1_inverted_out; end
      default: begin end
    endcase
    // RQ7 pa1
    case (s[1])
      `PFDS_SEL_ALT1: begin per_oe[1] = spi_cs_oe_in; per_dat[1] = spi_chip_select_line; end
      `PFDS_SEL_ALT2: ana[1] = 1'b1;
      `PFDS_SEL_ALT3: ana[1] = 1'b1;
      default: begin end
    endcase
    // RQ6 pa2
    case (s[2])
      `PFDS_SEL_ALT1: begin per_oe[2] = spi_data_oe_in; per_dat[2] = spi_data_o_in; end
      `PFDS_SEL_ALT2: begin per_oe[2] = uart0_rxtx_oe_in; per_dat[2] = uart0_transmit; end
      `PFDS_SEL_ALT3: begin per_oe[2] = 1'b1; per_dat[2] = per_timer2_inverted_out; end
      default: begin end
    endcase
    // RQ5 pa3
    case (s[3])
      `PFDS_SEL_ALT1: begin per_oe[3] = 1'b1; per_dat[3] = spi_serial_out; end
      `PFDS_SEL_ALT2: begin per_oe[3] = 1'b1; per_dat[3] = uart0_transmit; end
      `PFDS_SEL_ALT3: ana[3] = 1'b1;
      default: begin end
    endcase
    // RQ12 pa4
    case (s[4])
      `PFDS_SEL_ALT1: begin per_oe[4] = 1'b1; per_dat[4] = std_timer0_inverted_out; end
      `PFDS_SEL_ALT2: ana[4] = 1'b1;
      `PFDS_SEL_ALT3: ana[4] = 1'b1;
      default: begin end
    endcase
    // RQ11 pa5; code 11 stays gpio
    case (s[5])
      `PFDS_SEL_ALT1: begin per_oe[5] = 1'b1; per_dat[5] = std_timer1_inverted_out; end
      `PFDS_SEL_ALT2: ana[5] = 1'b1;
      default: begin end
    endcase
    // RQ10 pa6
    case (s[6])
      `PFDS_SEL_ALT1: begin per_oe[6] = 1'b1; per_dat[6] = per_timer0_out; end
      `PFDS_SEL_ALT2: begin per_oe[6] = spi_data_oe_in; per_dat[6] = spi_data_o_in; end
      `PFDS_SEL_ALT3: begin per_oe[6] = uart0_rxtx_oe_in; per_dat[6] = uart0_transmit; end
      default: begin end
    endcase
    // RQ9 pa7
    case (s[7])
      `PFDS_SEL_ALT1: begin per_oe[7] = spi_sck_oe_in; per_dat[7] = spi_sck_in; end
      `PFDS_SEL_ALT2: ana[7] = 1'b1;
      `PFDS_SEL_ALT3: ana[7] = 1'b1;
      default: begin end
    endcase
    // RQ16 pb0
    case (s[8])
      `PFDS_SEL_ALT1: begin per_oe[8] = 1'b1; per_dat[8] = std_timer0_out; end
      `PFDS_SEL_ALT2: ana[8] = 1'b1;
      `PFDS_SEL_ALT3: ana[8] = 1'b1;
      default: begin end
    endcase
    // RQ15 pb1
    case (s[9])
      `PFDS_SEL_ALT1: begin per_oe[9] = 1'b1; per_dat[9] = powerline_transmit_out; end
      `PFDS_SEL_ALT2: begin per_oe[9] = 1'b1; per_dat[9] = spi_serial_out; end
      `PFDS_SEL_ALT3: begin per_oe[9] = 1'b1; per_dat[9] = uart0_transmit; end
      default: begin end
    endcase
    // RQ14 pb2; signal input is analog
    case (s[10])
      `PFDS_SEL_ALT1: ana[10] = 1'b1;
      `PFDS_SEL_ALT2: begin per_oe[10] = spi_sck_oe_in; per_dat[10] = spi_sck_in; end
      `PFDS_SEL_ALT3: ana[10] = 1'b1;
      default: begin end
    endcase
    // RQ13 pb3
    case (s[11])
      `PFDS_SEL_ALT2: begin per_oe[11] = spi_data_oe_in; per_dat[11] = spi_data_o_in; end
      `PFDS_SEL_ALT3: begin per_oe[11] = uart0_rxtx_oe_in; per_dat[11] = uart0_transmit; end
      default: begin end
    endcase
  end

  //----------------------------------------
  // pin cells and output flops
  //----------------------------------------
  wire [11:0] cell_pin;
  wire [11:0] cell_oe;
  wire [23:0] cell_drv;
  // RQ2 group drive fields per pin
  wire [23:0] grp_drv;
  assign grp_drv = {{4{drv_low_q[5:4]}}, {4{drv_low_q[3:2]}}, {4{drv_low_q[1:0]}}};
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1) begin : g_pin
      pfds_pin_cell u_cell (
        .dir_in_in   (dir_q[gi]),
        .latch_in    (data_q[gi]),
        .per_oe_in   (per_oe[gi]),
        .per_data_in (per_dat[gi]),
        .analog_in   (ana[gi]),
        .drive_in    (grp_drv[2*gi+1:2*gi]),
        .pin_out     (cell_pin[gi]),
        .pin_oe_out  (cell_oe[gi]),
        .drive_out   (cell_drv[2*gi+1:2*gi])
      );
    end
  endgenerate

  // gpio input qualifier: direction input, no peripheral output and not analog; code checked at each use
  wire [11:0] gin;
  // RQ17 shared inputs need input
  assign gin = dir_q & ~per_oe & ~ana & pin_s2_q;

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_data_out               <= 12'h000;
      pin_oe_out                 <= 12'h000;
      pin_analog_out             <= 12'h000;
      pin_drive_out              <= 24'h000000;
      external_irq_line_0_out    <= 1'b0;
      external_irq_line_1_out    <= 1'b0;
      std_timer1_capture_in_out  <= 1'b0;
      std_timer0_capture_in_out  <= 1'b0;
      per_timer0_capture_in_out  <= 1'b0;
      std_timer0_clock_in_out    <= 1'b0;
      per_timer0_clock_in_out    <= 1'b0;
      spi_in_or_i2c_data_out     <= 1'b0;
      spi_sck_out                <= 1'b0;
      spi_chip_select_in_out     <= 1'b0;
      uart0_receive_transmit_out <= 1'b0;
      powerline_receive_in_out   <= 1'b0;
      powerline_signal_input_out <= 1'b0;
    end else begin
      pin_data_out   <= cell_pin;
      pin_oe_out     <= cell_oe;
      pin_analog_out <= ana;
      pin_drive_out  <= cell_drv;
      // RQ17 gpio-coded inputs gated
      external_irq_line_0_out   <= (s[3] == `PFDS_SEL_GPIO & gin[3]) | (s[8] == `PFDS_SEL_GPIO & gin[8]);
      external_irq_line_1_out   <= (s[1] == `PFDS_SEL_GPIO) & gin[1];
      std_timer1_capture_in_out <= (s[3] == `PFDS_SEL_GPIO) & gin[3];
      std_timer0_capture_in_out <= (s[7] == `PFDS_SEL_GPIO) & gin[7];
      per_timer0_capture_in_out <= (s[7] == `PFDS_SEL_GPIO) & gin[7];
      std_timer0_clock_in_out   <= ((s[5] == `PFDS_SEL_GPIO) | (s[5] == `PFDS_SEL_ALT3)) & gin[5];
      per_timer0_clock_in_out   <= (s[4] == `PFDS_SEL_GPIO) & gin[4];
      // RQ21 route pin to peripheral
      spi_in_or_i2c_data_out     <= (s[2] == `PFDS_SEL_ALT1 & pin_s2_q[2])
                                  | (s[6] == `PFDS_SEL_ALT2 & pin_s2_q[6])
                                  | (s[11] == `PFDS_SEL_ALT2 & pin_s2_q[11]);
      spi_sck_out                <= (s[0] == `PFDS_SEL_ALT1 & pin_s2_q[0])
                                  | (s[7] == `PFDS_SEL_ALT1 & pin_s2_q[7])
                                  | (s[10] == `PFDS_SEL_ALT2 & pin_s2_q[10]);
      spi_chip_select_in_out     <= (s[1] == `PFDS_SEL_ALT1) & pin_s2_q[1];
      uart0_receive_transmit_out <= (s[2] == `PFDS_SEL_ALT2 & pin_s2_q[2])
                                  | (s[6] == `PFDS_SEL_ALT3 & pin_s2_q[6])
                                  | (s[11] == `PFDS_SEL_ALT3 & pin_s2_q[11]);
      powerline_receive_in_out   <= (s[11] == `PFDS_SEL_ALT1) & pin_s2_q[11];
      powerline_signal_input_out <= (s[10] == `PFDS_SEL_ALT1) & pin_s2_q[10];
    end
  end
  // RQ18 RQ19 sequencing is software's duty
endmodule
`default_nettype wire

/* verif/pfds_chk.sv */
// Purpose: concurrent checks on the ports of pfds_top
// Assumes: one access per two cycles, selects shadowed from bus writes
// Notes:   pin functions judged only once the shadow has been quiet a while; drive_oe_a every cycle
`timescale 1ns/1ns
`default_nettype none
module pfds_chk (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_readdata_out,
  input  wire logic        avs_waitrequest_out,
  input  wire logic [11:0] pin_level_in,
  input  wire logic [11:0] pin_data_out,
  input  wire logic [11:0] pin_oe_out,
  input  wire logic [11:0] pin_analog_out,
  input  wire logic [23:0] pin_drive_out,
  input  wire logic        uart0_transmit,
  input  wire logic        powerline_transmit_out,
  input  wire logic        std_timer0_out,
  input  wire logic        external_irq_line_1_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [7:0]  pa_lo_q;
  logic [7:0]  pb_lo_q;
  logic        dir1_q;
  logic [2:0]  quiet_q;
  logic [23:0] oe_wide;
  wire         wr_ack = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  // shadow selects; quiet counter saturates so pipelines have settled
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pa_lo_q <= 8'h00;
      pb_lo_q <= 8'h00;
      dir1_q  <= 1'b1;
      quiet_q <= 3'h0;
    end else begin
      if (wr_ack && avs_address_in[4:2] == 3'h2) pa_lo_q <= avs_writedata_in[7:0];
      if (wr_ack && avs_address_in[4:2] == 3'h4) pb_lo_q <= avs_writedata_in[7:0];
      if (wr_ack && avs_address_in[4:2] == 3'h5) dir1_q <= avs_writedata_in[1];
      quiet_q <= wr_ack ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
    end
  end
  for (genvar i = 0; i < 12; i++) begin : g_oe
    assign oe_wide[2*i+1:2*i] = {2{pin_oe_out[i]}};
  end
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("access not answered in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  read_upper_a: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:12] == 20'h0)
    else $error("read data upper bits not zero");
  drv_high_top_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in[4:2] == 3'h1 |-> avs_readdata_out[7:6] == 2'h0)
    else $error("unimplemented drive bits read nonzero");
  drive_oe_a: assert property ((pin_drive_out & ~oe_wide) == 24'h0)
    else $error("drive level on a pin that is not driven");
  pa3_uart_a: assert property (quiet_q > 3'h2 && pa_lo_q[7:6] == 2'h2 |-> pin_oe_out[3] && pin_data_out[3] == $past(uart0_transmit))
    else $error("pin a3 not carrying uart transmit");
  pa3_analog_a: assert property (quiet_q > 3'h2 && pa_lo_q[7:6] == 2'h3 |-> pin_analog_out[3] && !pin_oe_out[3])
    else $error("pin a3 not analog");
  pb1_powerline_transmit_out_a: assert property (quiet_q > 3'h2 && pb_lo_q[3:2] == 2'h1 |-> pin_oe_out[9] && pin_data_out[9] == $past(powerline_transmit_out))
    else $error("pin b1 not carrying powerline transmit");
  pb0_timer_a: assert property (quiet_q > 3'h2 && pb_lo_q[1:0] == 2'h1 |-> pin_oe_out[8] && pin_data_out[8] == $past(std_timer0_out))
    else $error("pin b0 not carrying timer output");
  irq1_route_a: assert property (quiet_q == 3'h7 && pa_lo_q[3:2] == 2'h0 && dir1_q |-> external_irq_line_1_out == $past(pin_level_in[1], 3))
    else $error("interrupt line does not follow pin a1");
  cover property (wr_ack);
  cover property (quiet_q == 3'h7 && pa_lo_q[7:6] == 2'h3);
  cover property ($rose(external_irq_line_1_out));
endmodule
`default_nettype wire

/* verif/pfds_pins.sv */
// Purpose: far side model, pins and on-chip peripheral outputs
// Assumes: pins not driven by the block take the bench's external level
// Notes:   peripheral outputs come from a shift pattern changing every cycle
`timescale 1ns/1ns
`default_nettype none
module pfds_pins (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [11:0] pin_data_in,
  input  wire logic [11:0] pin_oe_in,
  input  wire logic [11:0] ext_level_in,
  output logic      [11:0] pin_level_out,
  output logic      [15:0] per_out
);
  // driven pin shows the block data
  assign pin_level_out = (pin_oe_in & pin_data_in) | (~pin_oe_in & ext_level_in);
  // busy peripheral outputs so a stuck pin path shows up
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) per_out <= 16'hace1;
    else per_out <= {per_out[14:0], per_out[15] ^ per_out[13] ^ per_out[12] ^ per_out[10]};
  end
endmodule
`default_nettype wire

/* verif/pfds_bench.sv */
// Purpose: self-checking bench for pfds_top
// Assumes: Avalon answer one cycle after a request is presented
// Notes:   scenario tasks judge the block before returning
`timescale 1ns/1ns
`default_nettype none
module pfds_bench;
  logic        clk_in, arst_n_in, rd, wr;
  logic [4:0]  adr;
  logic [31:0] wd, rdata;
  logic [3:0]  be;
  logic [11:0] ext;
  wire  [31:0] rdo;
  wire         wq, irq1, powerline_receive_in;
  wire  [5:0]  gi;
  wire  [11:0] lvl, pdat, poe, pan;
  wire  [23:0] pdrv;
  wire  [15:0] per;
  int          n_fail, check_count;
  // one select entry: address, value, pin, {analog, oe}
  localparam logic [27:0] tbl [24] = '{28'h08_40_03_1, 28'h08_80_03_1, 28'h08_c0_03_2, 28'h08_30_02_1,
    28'h08_08_01_2, 28'h08_0c_01_2, 28'h08_02_00_1, 28'h08_03_00_0, 28'h0c_80_07_2, 28'h0c_c0_07_2,
    28'h0c_10_06_1, 28'h0c_04_05_1, 28'h0c_08_05_2, 28'h0c_0c_05_0, 28'h0c_01_04_1, 28'h0c_02_04_2,
    28'h0c_03_04_2, 28'h10_40_0b_0, 28'h10_30_0a_2, 28'h10_04_09_1, 28'h10_0c_09_1, 28'h10_01_08_1,
    28'h10_02_08_2, 28'h10_03_08_2};
  pfds_top u_pfds_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdo),
    .avs_waitrequest_out(wq), .pin_level_in(lvl), .pin_data_out(pdat), .pin_oe_out(poe),
    .pin_analog_out(pan), .pin_drive_out(pdrv), .spi_serial_out(per[0]), .spi_sck_in(per[1]),
    .spi_sck_oe_in(per[2]), .spi_data_o_in(per[3]), .spi_data_oe_in(per[4]), .spi_chip_select_line(per[5]),
    .spi_cs_oe_in(per[6]), .uart0_transmit(per[7]), .uart0_rxtx_oe_in(per[8]),
    .per_timer2_inverted_out(per[9]), .per_timer1_inverted_out(per[10]), .per_timer0_out(per[11]),
    .std_timer1_inverted_out(per[12]), .std_timer0_inverted_out(per[13]), .std_timer0_out(per[14]),
    .powerline_transmit_out(per[15]), .external_irq_line_0_out(gi[0]), .external_irq_line_1_out(irq1),
    .std_timer1_capture_in_out(gi[1]), .std_timer0_capture_in_out(gi[2]), .per_timer0_capture_in_out(gi[3]),
    .std_timer0_clock_in_out(gi[4]), .per_timer0_clock_in_out(gi[5]), .spi_in_or_i2c_data_out(), .spi_sck_out(),
    .spi_chip_select_in_out(), .uart0_receive_transmit_out(), .powerline_receive_in_out(powerline_receive_in),
    .powerline_signal_input_out());
  pfds_pins u_pfds_pins (.clk_in(clk_in), .arst_n_in(arst_n_in), .pin_data_in(pdat), .pin_oe_in(poe),
    .ext_level_in(ext), .pin_level_out(lvl), .per_out(per));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // request held until the edge at which waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge clk_in);
    adr <= a; wd <= d; be <= b; wr <= w; rd <= !w;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
      if (k > 50) begin n_fail++; results; end
    end while (wq !== 1'b0);
    rdata = rdo;
    wr <= 1'b0; rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 4'h1);
    chk(rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd_chk(5'(4 * i), (i < 5) ? 32'h0 : 32'hfff);
    chk(32'(poe), 32'h0);
  endtask
  task automatic t_drv_reg;
    acc(1'b1, `PFDS_OFF_DRV_HIGH, 32'hff, 4'h1);
    rd_chk(`PFDS_OFF_DRV_HIGH, 32'h3f);
    acc(1'b1, `PFDS_OFF_DRV_LOW, 32'h55, 4'h0);
    rd_chk(`PFDS_OFF_DRV_LOW, 32'h0);
  endtask
  task automatic t_drive;
    logic [7:0] pat;
    acc(1'b1, `PFDS_OFF_PORT_DATA, 32'h0, 4'h1);
    acc(1'b1, `PFDS_OFF_PORT_DIR, 32'h0, 4'h1);
    for (int j = 0; j < 2; j++) begin
      pat = j ? 8'h1b : 8'he4;
      acc(1'b1, `PFDS_OFF_DRV_LOW, 32'(pat), 4'h1);
      cyc(3);
      for (int i = 0; i < 12; i++) chk(32'(pdrv[2*i+:2]), 32'((pat >> (2 * (i / 4))) & 8'h3));
    end
    acc(1'b1, `PFDS_OFF_PORT_DATA, 32'ha5, 4'h1);
    rd_chk(`PFDS_OFF_PIN_LEVEL, 32'h0a5);
    acc(1'b1, `PFDS_OFF_PORT_DIR, 32'hfff, 4'h1);
    cyc(3);
    chk(32'(pdrv), 32'h0);
    rd_chk(`PFDS_OFF_PIN_LEVEL, 32'(ext));
  endtask
  task automatic t_func;
    logic [27:0] e;
    int          p;
    acc(1'b1, `PFDS_OFF_DRV_LOW, 32'hff, 4'h1);
    for (int i = 0; i < 24; i++) begin
      e = tbl[i];
      p = e[11:4];
      acc(1'b1, e[24:20], 32'(e[19:12]), 4'h1);
      cyc(3);
      chk(32'({pan[p], poe[p]}), 32'(e[1:0]));
      chk(32'(pdrv[2*p+:2]), (e[1:0] == 2'h1) ? 32'h3 : 32'h0);
      // select returned to general use before the next choice
      acc(1'b1, e[24:20], 32'h0, 4'h1);
    end
  endtask
  task automatic t_route;
    // select written before the input is used
    acc(1'b1, `PFDS_OFF_PB_LOW, 32'h40, 4'h1);
    for (int v = 1; v >= 0; v--) begin
      ext <= {12{v[0]}};
      cyc(6);
      chk(32'(gi), v ? 32'h3f : 32'h0);
      chk(32'(irq1), 32'(v));
      chk(32'(powerline_receive_in), 32'(v));
    end
    acc(1'b1, `PFDS_OFF_PORT_DIR, 32'hffd, 4'h1);
    cyc(8);
  endtask
  // ----------------------------------------
  // clock, reset and run
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    arst_n_in = 1'b0; rd = 1'b0; wr = 1'b0; adr = 5'h0; wd = 32'h0; be = 4'h0; ext = 12'h3c6;
    n_fail = 0;
    check_count = 0;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    cyc(3);
    t_reset;
    t_drv_reg;
    t_drive;
    t_func;
    t_route;
    results;
  end
endmodule
bind pfds_top pfds_chk u_pfds_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .pin_level_in(pin_level_in), .pin_data_out(pin_data_out),
  .pin_oe_out(pin_oe_out), .pin_analog_out(pin_analog_out), .pin_drive_out(pin_drive_out),
  .uart0_transmit(uart0_transmit), .powerline_transmit_out(powerline_transmit_out),
  .std_timer0_out(std_timer0_out), .external_irq_line_1_out(external_irq_line_1_out));
`default_nettype wire
